// ### hdl/gpio_map.svh
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH
// register indices within one port's register block
`define OFF_MODE 4'h0
`define OFF_OTYPE 4'h1
`define OFF_PULL 4'h2
`define OFF_DRIVE 4'h3
`define OFF_SLEW 4'h4
`define OFF_IDATA 4'h5
`define OFF_ODATA 4'h6
`define OFF_BSET 4'h7
`define OFF_BCLR 4'h8
`define OFF_LOCK 4'h9
// port select lives in address bits 7:6, register index in bits 5:2
`define PORT_LSB 6
`define REG_LSB 2
`define MODE_RST 32'hffffffff
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define PORT_A_PINS 16
`define PORT_B_PINS 16
`define PORT_C_PINS 3
`define PORT_F_PINS 5
`endif

// ### hdl/gpio_pkg.sv
package gpio_pkg;
	typedef enum logic [1:0] {
		MODE_INPUT = 2'b00,
		MODE_OUTPUT = 2'b01,
		MODE_ALT = 2'b10,
		MODE_ANALOG = 2'b11
	} pin_mode_field_t;
	typedef struct packed {
		logic [31:0] pin_mode_field;
		logic [15:0] output_type_bit;
		logic [31:0] pull_select_field;
		logic [15:0] drive_strength_bit;
		logic [15:0] slew_rate_bit;
		logic [15:0] output_data_register;
		logic [15:0] input_data;
		logic [15:0] locked;
	} port_regs_t;
	typedef struct packed {
		logic [39:0] drive_out;
		logic [39:0] drive_en;
		logic [39:0] pull_up;
		logic [39:0] pull_down;
		logic [39:0] schmitt_en;
		logic [39:0] strong_drive;
		logic [39:0] fast_slew;
	} pad_ctrl_t;
endpackage

// ### hdl/gpio_pin_mode_config.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpio_map.svh"
// What this block does
// [R1] forty pins in four ports of sixteen, sixteen, three and five pins
// [R2] software uses only full 32-bit word accesses to these registers
// [R3] mode 01 is output; type bit picks push-pull or open-drain; pull field
// [R4] mode 10 is alternate function with the same type and pull encodings
// [R5] mode 00 is input, type bit ignored, pull none, up or down
// [R6] mode 11 with pull 00 is analog; other pull values are reserved
// [R7] analog turns off pulls, buffer and schmitt; input data reads zero
// [R8] pin levels are sampled into input data every clock
// [R9] open-drain drives low for zero and floats for one
// [R10] push-pull drives low for zero and high for one
// [R11] output data reads back the last written value
// [R12] input mode keeps the output buffer off
// [R13] alternate mode drives the buffer from the peripheral signal
// [R14] each pin has a drive strength bit and a slew rate bit
// [R15] schmitt input enabled in input, output and alternate modes
// [R16] lock holds pin configuration until reset
// [R17] set and clear registers change only bits written with one
// [R18] reset puts every pin in analog mode
// [R19] each port keeps mode, type, pull, drive and slew fields per pin
module gpio_pin_mode_config #(
	parameter int NPORT = 4
) (
	input wire logic I_REF_CLK,
	input wire logic I_RST_B,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [7:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic [39:0] I_PIN_IN,
	input wire logic [39:0] I_ALT_OUT,
	input wire logic [39:0] I_ALT_OE,
	output logic [39:0] O_PIN_OUT,
	output logic [39:0] O_PIN_OE,
	output logic [39:0] O_PULL_UP,
	output logic [39:0] O_PULL_DOWN,
	output logic [39:0] O_SCHMITT_EN,
	output logic [39:0] O_STRONG_DRIVE,
	output logic [39:0] O_FAST_SLEW,
	output logic [39:0] O_PIN_IN_INTERNAL
);
	// pin base of each port in the flat 40-pin vectors: A 0, B 16, C 32, F 35
	localparam int PORT_BASE [4] = '{0, `PORT_A_PINS,
		`PORT_A_PINS + `PORT_B_PINS,
		`PORT_A_PINS + `PORT_B_PINS + `PORT_C_PINS};
	localparam int PORT_W [4] = '{`PORT_A_PINS, `PORT_B_PINS,
		`PORT_C_PINS, `PORT_F_PINS}; // [R1]

	gpio_pkg::port_regs_t regs [NPORT];
	gpio_pkg::pad_ctrl_t next_pad;
	logic aw_held, w_held;
	logic [7:0] awaddr;
	logic [31:0] wdata;
	logic do_write;
	logic [1:0] wport;
	logic [3:0] wreg;

	function automatic logic [15:0] port_mask(input int p);
		port_mask = 16'(({16'h0, 16'hffff} << PORT_W[p]) >> 16);
	endfunction

	// pulls are reserved for 11; keep them off rather than fight both ways
	function automatic logic [1:0] pull_of(input logic [1:0] mode,
		input logic [1:0] pull);
		if (mode == 2'(gpio_pkg::MODE_ANALOG)) begin
			pull_of = 2'b00; // [R6] [R7]
		end else if (pull == 2'b11) begin
			pull_of = 2'b00; // [R3] [R4] [R5]
		end else begin
			pull_of = pull;
		end
	endfunction

	// write channels: address and data may arrive in either order
	assign do_write = aw_held && w_held && !O_BVALID;
	assign wport = awaddr[`PORT_LSB+:2];
	assign wreg = awaddr[`REG_LSB+:4];

	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr <= 8'h00;
			wdata <= 32'h0;
			O_AWREADY <= 1'b1;
			O_WREADY <= 1'b1;
			O_BVALID <= 1'b0;
			O_BRESP <= `RESP_OKAY;
		end else begin
			if (I_AWVALID && O_AWREADY) begin
				aw_held <= 1'b1;
				awaddr <= I_AWADDR;
				O_AWREADY <= 1'b0;
			end
			if (I_WVALID && O_WREADY) begin
				w_held <= 1'b1;
				// partial strobes are ignored below, never merged
				wdata <= I_WDATA;
				O_WREADY <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				O_BVALID <= 1'b1;
				O_BRESP <= (wreg > `OFF_LOCK || wreg == `OFF_IDATA)
					? `RESP_SLVERR : `RESP_OKAY;
			end
			if (O_BVALID && I_BREADY) begin
				O_BVALID <= 1'b0;
				O_AWREADY <= 1'b1;
				O_WREADY <= 1'b1;
			end
		end
	end

	logic [3:0] wstrb_q;
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			wstrb_q <= 4'h0;
		end else if (I_WVALID && O_WREADY) begin
			wstrb_q <= I_WSTRB;
		end
	end

	// register storage per port
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			for (int p = 0; p < NPORT; p++) begin
				regs[p] <= '0;
				regs[p].pin_mode_field <= `MODE_RST; // [R18]
			end
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				logic [15:0] m;
				logic [31:0] m2;
				logic [15:0] lk;
				m = port_mask(p);
				lk = regs[p].locked;
				for (int b = 0; b < 16; b++) begin
					m2[2*b+:2] = {2{m[b] & ~lk[b]}};
				end
				for (int b = 0; b < 16; b++) begin
					// analog pins read zero; others follow the pad
					if (b < PORT_W[p]) begin
						regs[p].input_data[b] <=
							(regs[p].pin_mode_field[2*b+:2] ==
							2'(gpio_pkg::MODE_ANALOG)) ? 1'b0
							: I_PIN_IN[PORT_BASE[p]+b]; // [R7] [R8]
					end else begin
						regs[p].input_data[b] <= 1'b0;
					end
				end
				// full-word writes only; anything narrower is ignored
				if (do_write && wport == 2'(p) && wstrb_q == 4'hf) begin // [R2]
					case (wreg)
					`OFF_MODE: regs[p].pin_mode_field <=
						(regs[p].pin_mode_field & ~m2)
						| (wdata & m2); // [R16] [R19]
					`OFF_OTYPE: regs[p].output_type_bit <=
						(regs[p].output_type_bit & ~(m & ~lk))
						| (wdata[15:0] & m & ~lk); // [R16]
					`OFF_PULL: regs[p].pull_select_field <=
						(regs[p].pull_select_field & ~m2)
						| (wdata & m2); // [R16]
					`OFF_DRIVE: regs[p].drive_strength_bit <=
						(regs[p].drive_strength_bit & ~(m & ~lk))
						| (wdata[15:0] & m & ~lk); // [R14]
					`OFF_SLEW: regs[p].slew_rate_bit <=
						(regs[p].slew_rate_bit & ~(m & ~lk))
						| (wdata[15:0] & m & ~lk); // [R14]
					`OFF_ODATA: regs[p].output_data_register <=
						wdata[15:0] & m; // [R11]
					`OFF_BSET: regs[p].output_data_register <=
						regs[p].output_data_register
						| (wdata[15:0] & m); // [R17]
					`OFF_BCLR: regs[p].output_data_register <=
						regs[p].output_data_register
						& ~wdata[15:0]; // [R17]
					`OFF_LOCK: regs[p].locked <=
						lk | (wdata[15:0] & m); // [R16]
					default: ;
					endcase
				end
			end
		end
	end

	// read channel, one cycle after the address is taken
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_ARREADY <= 1'b1;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0;
			O_RRESP <= `RESP_OKAY;
		end else begin
			if (I_ARVALID && O_ARREADY) begin
				logic [1:0] rp;
				logic [3:0] rr;
				rp = I_ARADDR[`PORT_LSB+:2];
				rr = I_ARADDR[`REG_LSB+:4];
				O_ARREADY <= 1'b0;
				O_RVALID <= 1'b1;
				O_RRESP <= `RESP_OKAY;
				case (rr)
				`OFF_MODE: O_RDATA <= regs[rp].pin_mode_field;
				`OFF_OTYPE: O_RDATA <= {16'h0, regs[rp].output_type_bit};
				`OFF_PULL: O_RDATA <= regs[rp].pull_select_field;
				`OFF_DRIVE: O_RDATA <= {16'h0, regs[rp].drive_strength_bit};
				`OFF_SLEW: O_RDATA <= {16'h0, regs[rp].slew_rate_bit};
				`OFF_IDATA: O_RDATA <= {16'h0, regs[rp].input_data}; // [R7]
				`OFF_ODATA: O_RDATA <= {16'h0,
					regs[rp].output_data_register}; // [R11]
				`OFF_LOCK: O_RDATA <= {16'h0, regs[rp].locked};
				`OFF_BSET, `OFF_BCLR: O_RDATA <= 32'h0;
				default: begin
					O_RDATA <= 32'h0;
					O_RRESP <= `RESP_SLVERR;
				end
				endcase
			end
			if (O_RVALID && I_RREADY) begin
				O_RVALID <= 1'b0;
				O_ARREADY <= 1'b1;
			end
		end
	end

	// pad control, decoded per pin
	always_comb begin
		next_pad = '0;
		for (int p = 0; p < NPORT; p++) begin
			for (int b = 0; b < PORT_W[p]; b++) begin
				logic [1:0] md;
				logic [1:0] pl;
				logic od;
				logic dv;
				logic en;
				int k;
				k = PORT_BASE[p] + b;
				md = regs[p].pin_mode_field[2*b+:2];
				pl = pull_of(md, regs[p].pull_select_field[2*b+:2]);
				od = regs[p].output_type_bit[b];
				dv = 1'b0;
				en = 1'b0;
				case (gpio_pkg::pin_mode_field_t'(md))
				gpio_pkg::MODE_OUTPUT: begin
					dv = regs[p].output_data_register[b]; // [R3]
					en = 1'b1;
				end
				gpio_pkg::MODE_ALT: begin
					dv = I_ALT_OUT[k]; // [R13]
					en = I_ALT_OE[k]; // [R4]
				end
				default: begin
					dv = 1'b0; // [R12] [R7]
					en = 1'b0;
				end
				endcase
				// open-drain never drives high: a one releases the pin
				if (en && od) begin
					next_pad.drive_out[k] = 1'b0; // [R9]
					next_pad.drive_en[k] = ~dv; // [R9]
				end else begin
					next_pad.drive_out[k] = dv; // [R10]
					next_pad.drive_en[k] = en; // [R10]
				end
				next_pad.pull_up[k] = (pl == 2'b01);
				next_pad.pull_down[k] = (pl == 2'b10);
				next_pad.schmitt_en[k] = (md !=
					2'(gpio_pkg::MODE_ANALOG)); // [R15] [R7]
				next_pad.strong_drive[k] = regs[p].drive_strength_bit[b];
				next_pad.fast_slew[k] = regs[p].slew_rate_bit[b]; // [R14]
			end
		end
	end

	// pads are registered so every pin output comes from a flip-flop
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_PIN_OUT <= 40'h0;
			O_PIN_OE <= 40'h0;
			O_PULL_UP <= 40'h0;
			O_PULL_DOWN <= 40'h0;
			O_SCHMITT_EN <= 40'h0; // [R18]
			O_STRONG_DRIVE <= 40'h0;
			O_FAST_SLEW <= 40'h0;
			O_PIN_IN_INTERNAL <= 40'h0;
		end else begin
			O_PIN_OUT <= next_pad.drive_out;
			O_PIN_OE <= next_pad.drive_en;
			O_PULL_UP <= next_pad.pull_up;
			O_PULL_DOWN <= next_pad.pull_down;
			O_SCHMITT_EN <= next_pad.schmitt_en;
			O_STRONG_DRIVE <= next_pad.strong_drive;
			O_FAST_SLEW <= next_pad.fast_slew;
			// analog pins feed a forced low to the peripherals
			O_PIN_IN_INTERNAL <= I_PIN_IN & next_pad.schmitt_en; // [R7]
		end
	end
endmodule
`default_nettype wire

// ### sim/gpio_pin_mode_config_props.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_mode_config_props (
	input wire logic I_REF_CLK,
	input wire logic I_RST_B,
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic [1:0] O_BRESP,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic [31:0] O_RDATA,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic [39:0] I_PIN_IN,
	input wire logic [39:0] O_PIN_OE,
	input wire logic [39:0] O_PULL_UP,
	input wire logic [39:0] O_PULL_DOWN,
	input wire logic [39:0] O_SCHMITT_EN,
	input wire logic [39:0] O_PIN_IN_INTERNAL
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_B);
	property p_rst; $rose(I_RST_B) |-> (O_SCHMITT_EN | O_PIN_OE) == 40'h0;
	endproperty
	a_rst: assert property (p_rst)
		else $error("pads not analog at reset");
	// analog pins must be fully quiet, or they draw current
	property p_ana; (~O_SCHMITT_EN & (O_PULL_UP | O_PULL_DOWN | O_PIN_OE
		| O_PIN_IN_INTERNAL)) == 40'h0; endproperty
	a_ana: assert property (p_ana)
		else $error("analog pin not quiet");
	property p_pull; (O_PULL_UP & O_PULL_DOWN) == 40'h0; endproperty
	a_pull: assert property (p_pull)
		else $error("both pulls on");
	property p_samp;
		O_PIN_IN_INTERNAL == ($past(I_PIN_IN) & O_SCHMITT_EN);
	endproperty
	a_samp: assert property (p_samp)
		else $error("input not sampled");
	property p_aw;
		I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:2] O_BVALID;
	endproperty
	a_aw: assert property (p_aw)
		else $error("no write response");
	property p_b; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
	endproperty
	a_b: assert property (p_b)
		else $error("write response dropped");
	property p_ar; I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY;
	endproperty
	a_ar: assert property (p_ar)
		else $error("no read response");
	property p_r; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
	endproperty
	a_r: assert property (p_r)
		else $error("read data dropped");
endmodule
bind gpio_pin_mode_config gpio_pin_mode_config_props props_inst (
	.I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_AWVALID(I_AWVALID),
	.O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
	.O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
	.I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
	.O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .I_PIN_IN(I_PIN_IN),
	.O_PIN_OE(O_PIN_OE), .O_PULL_UP(O_PULL_UP), .O_PULL_DOWN(O_PULL_DOWN),
	.O_SCHMITT_EN(O_SCHMITT_EN), .O_PIN_IN_INTERNAL(O_PIN_IN_INTERNAL));
`default_nettype wire

// ### sim/gpio_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_model (
	input wire logic i_clk,
	input wire logic [39:0] i_out,
	input wire logic [39:0] i_oe,
	input wire logic [39:0] i_pu,
	input wire logic [39:0] i_pd,
	input wire logic [39:0] i_ext_en,
	input wire logic [39:0] i_ext_val,
	output logic [39:0] o_level
);
	// a floating pin wanders, so the design never sees a steady value
	logic [39:0] noise = 40'h0;
	always @(posedge i_clk) noise <= ~noise;
	assign o_level = (i_oe & i_out)
		| (~i_oe & i_ext_en & i_ext_val)
		| (~i_oe & ~i_ext_en & (i_pu | (~i_pd & noise)));
endmodule
`default_nettype wire

// ### sim/gpio_pin_mode_config_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpio_map.svh"
module gpio_pin_mode_config_tb;
	logic clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
	logic arv = 1'b0, rry = 1'b0;
	logic [7:0] awa = 8'h0, ara = 8'h0;
	logic [31:0] wd = 32'h0, r, s, c, v;
	logic [3:0] ws = 4'h0;
	logic [39:0] alt_o = '0, alt_e = '0, ext_e = '0, ext_v = '0;
	logic awr, wr_, bv, arr, rv;
	logic [1:0] br, rr, resp;
	logic [31:0] rd;
	logic [39:0] pin, pout, poe, pu, pd, sch, sd, fs, pii;
	int errors = 0, n_compared = 0, cyc = 0;
	gpio_pin_mode_config gpio_pin_mode_config_inst (.I_REF_CLK(clk),
		.I_RST_B(rst_b), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr),
		.I_WDATA(wd), .I_WSTRB(ws), .I_WVALID(wv), .O_WREADY(wr_),
		.O_BRESP(br), .O_BVALID(bv), .I_BREADY(bry), .I_ARADDR(ara),
		.I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rd), .O_RRESP(rr),
		.O_RVALID(rv), .I_RREADY(rry), .I_PIN_IN(pin), .I_ALT_OUT(alt_o),
		.I_ALT_OE(alt_e), .O_PIN_OUT(pout), .O_PIN_OE(poe), .O_PULL_UP(pu),
		.O_PULL_DOWN(pd), .O_SCHMITT_EN(sch), .O_STRONG_DRIVE(sd),
		.O_FAST_SLEW(fs), .O_PIN_IN_INTERNAL(pii));
	gpio_pad_model gpio_pad_model_inst (.i_clk(clk), .i_out(pout),
		.i_oe(poe), .i_pu(pu), .i_pd(pd), .i_ext_en(ext_e),
		.i_ext_val(ext_v), .o_level(pin));
	initial begin
		forever #50 clk = ~clk;
	end
	task report_and_stop;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			report_and_stop();
		end
	end
	task chk(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		chk(40'(got), 40'(exp));
	endtask
	task chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk(40'(got), 40'(exp));
	endtask
	task fin(input string t);
		$display("test %s done", t);
	endtask
	function logic [7:0] ad(input int p, input logic [3:0] i);
		return {2'(p), i, 2'b00};
	endfunction
	function logic [31:0] exp_sc(input logic [31:0] o, s, c);
		return (o | s) & ~c & 32'hffff;
	endfunction
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		ws <= st;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr_) wv <= 1'b0;
			aw_ok |= awr;
			w_ok |= wr_;
		end
		do @(posedge clk); while (!bv);
		resp = br;
		bry <= 1'b0;
	endtask
	task rd_(input logic [7:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		do @(posedge clk); while (!rv);
		v = rd;
		resp = rr;
		rry <= 1'b0;
	endtask
	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	initial begin
		r = $urandom(32'hf5fbeec1);
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		ext_e <= '1;
		ext_v <= 40'({$urandom, $urandom});
		rd_(ad(0, `OFF_MODE));
		chk_word(v, `MODE_RST);
		rd_(ad(1, `OFF_IDATA));
		chk_word(v, 32'h0);
		fin("reset");
		r = $urandom & 32'hffff;
		wr(ad(0, `OFF_ODATA), r, 4'hf);
		chk_resp(resp, `RESP_OKAY);
		wr(ad(0, `OFF_MODE), 32'h55555555, 4'hf);
		settle;
		chk(poe[15:0], 16'hffff);
		chk(pout[15:0], r[15:0]);
		chk(pii[15:0], r[15:0]);
		rd_(ad(0, `OFF_IDATA));
		chk_word(v, r);
		// input data is read-only, so a write there is refused
		wr(ad(0, `OFF_IDATA), 32'h0, 4'hf);
		chk_resp(resp, `RESP_SLVERR);
		s = $urandom;
		c = $urandom;
		wr(ad(0, `OFF_BSET), s, 4'hf);
		wr(ad(0, `OFF_BCLR), c, 4'hf);
		r = exp_sc(r, s, c);
		rd_(ad(0, `OFF_ODATA));
		chk_word(v, r);
		wr(ad(0, `OFF_OTYPE), 32'hffff, 4'hf);
		settle;
		chk(poe[15:0], {~r[15:0]});
		chk(pout & poe, 40'h0);
		// a narrow strobe must leave the register alone
		wr(ad(0, `OFF_ODATA), ~r, 4'h1);
		chk_resp(resp, `RESP_OKAY);
		rd_(ad(0, `OFF_ODATA));
		chk_word(v, r);
		fin("output");
		ext_e <= '0;
		wr(ad(1, `OFF_MODE), 32'h0, 4'hf);
		wr(ad(1, `OFF_PULL), 32'h55555555, 4'hf);
		settle;
		chk(pu[31:16], 16'hffff);
		chk(poe[31:16], 16'h0);
		chk(sch[31:16], 16'hffff);
		rd_(ad(1, `OFF_IDATA));
		chk_word(v, 32'hffff);
		// reserved pull code gives no pull at all
		wr(ad(1, `OFF_PULL), 32'hffffffff, 4'hf);
		settle;
		chk(pu[31:16] | pd[31:16], 16'h0);
		wr(ad(1, `OFF_PULL), 32'haaaaaaaa, 4'hf);
		settle;
		chk(pd[31:16], 16'hffff);
		rd_(ad(1, `OFF_IDATA));
		chk_word(v, 32'h0);
		fin("input");
		alt_o <= 40'({$urandom, $urandom});
		alt_e <= 40'({$urandom, $urandom});
		wr(ad(2, `OFF_MODE), 32'h2a, 4'hf);
		settle;
		chk(poe[34:32], alt_e[34:32]);
		chk(pout[34:32] & alt_e[34:32], alt_o[34:32] & alt_e[34:32]);
		wr(ad(2, `OFF_OTYPE), 32'h7, 4'hf);
		settle;
		chk(pout[34:32], 3'h0);
		chk(poe[34:32], {alt_e[34:32] & ~alt_o[34:32]});
		wr(ad(2, `OFF_ODATA), 32'hffffffff, 4'hf);
		rd_(ad(2, `OFF_ODATA));
		chk_word(v, 32'h7);
		r = $urandom;
		wr(ad(3, `OFF_DRIVE), r, 4'hf);
		wr(ad(3, `OFF_SLEW), ~r, 4'hf);
		wr(ad(3, `OFF_PULL), 32'h155, 4'hf);
		settle;
		chk(sd[39:35], r[4:0]);
		chk(fs[39:35], {~r[4:0]});
		chk(pu[39:35], 5'h0);
		chk(pii[39:35], 5'h0);
		fin("alt");
		wr(ad(0, `OFF_LOCK), 32'hffff, 4'hf);
		wr(ad(0, `OFF_MODE), 32'h0, 4'hf);
		rd_(ad(0, `OFF_MODE));
		chk_word(v, 32'h55555555);
		rd_(ad(0, 4'ha));
		chk_resp(resp, `RESP_SLVERR);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		rd_(ad(0, `OFF_MODE));
		chk_word(v, `MODE_RST);
		// reset drops the lock, so the mode field takes writes again
		wr(ad(0, `OFF_MODE), 32'h0, 4'hf);
		rd_(ad(0, `OFF_MODE));
		chk_word(v, 32'h0);
		fin("lock");
		report_and_stop();
	end
endmodule
`default_nettype wire
